// [src/mdc_pkg.sv]
// Constants shared by the motion-detection configuration register block.
package mdc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int ADDR_WIDTH = 6;
  localparam int DATA_WIDTH = 8;
  localparam logic [5:0] MODE_CONTROL_OFFSET = 6'h16;
  localparam logic [5:0] DETECTION_CONTROL_OFFSET = 6'h18;
  localparam logic [5:0] DETECTION_POLARITY_CONTROL_OFFSET = 6'h19;
  localparam logic [5:0] LEVEL_THRESHOLD_OFFSET = 6'h1A;
  localparam logic [5:0] PULSE_THRESHOLD_OFFSET = 6'h1B;
  localparam logic [5:0] PULSE_DURATION_OFFSET = 6'h1C;
  localparam logic [5:0] PULSE_LATENCY_TIME_OFFSET = 6'h1D;
  localparam logic [5:0] SECOND_PULSE_WINDOW_OFFSET = 6'h1E;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] POLARITY_USED_MASK = 8'h07;
  localparam int FILTER_BANDWIDTH_BIT = 7;
  localparam int THRESHOLD_OPTION_BIT = 6;
  localparam int OUTPUT_DRIVE_BIT = 2;
  localparam int PULSE_POLARITY_BIT = 1;
  localparam int LEVEL_POLARITY_BIT = 0;
  localparam int MODE_LSB = 0;
  localparam int RANGE_LSB = 2;
  localparam int SIGN_BIT = 7;

  // ****************************************************************
  // Operating modes, ranges and output encoding
  // ****************************************************************
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MEASURE = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam logic [1:0] RANGE_8G = 2'h0;
  localparam logic [1:0] RANGE_2G = 2'h1;
  localparam logic [1:0] RANGE_4G = 2'h2;
  localparam logic [7:0] ONE_G_2G = 8'h3F;
  localparam logic [7:0] ONE_G_4G = 8'h1F;
  localparam logic [7:0] ONE_G_8G = 8'h0F;
  localparam logic [7:0] FULL_SCALE_NEGATIVE = 8'h80;
  localparam logic [7:0] OUTPUT_ZERO = 8'h00;
  localparam logic [7:0] FULL_SCALE_POSITIVE = 8'h7F;
  localparam logic [16:0] FILTER_LOW_MILLIHZ = 17'h0F424;
  localparam logic [16:0] FILTER_HIGH_MILLIHZ = 17'h1E848;
  localparam logic [7:0] SINGLE_PULSE_WINDOW_MAX = 8'h01;

  // ****************************************************************
  // Serial frame layout, counted in link clock bits
  // ****************************************************************
  localparam logic [4:0] HEADER_BITS = 5'h08;
  localparam logic [4:0] WAIT_BITS = 5'h04;
  localparam logic [4:0] DATA_BITS = 5'h08;
  localparam logic [4:0] DATA_START = HEADER_BITS + WAIT_BITS;
  localparam logic [4:0] FRAME_BITS = DATA_START + DATA_BITS;
  localparam int CMD_WIDTH = 1 + ADDR_WIDTH + DATA_WIDTH;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int HALF_MS_STEP_PS = 500_000_000;
  localparam int HALF_MS_CYCLES = HALF_MS_STEP_PS / CLOCK_PERIOD_PS;

  typedef enum logic [1:0] {
    LINK_HEADER,
    LINK_WAIT,
    LINK_DATA,
    LINK_DONE
  } mdc_link_state_type;

endpackage : mdc_pkg

// [src/mdc_word_cross.sv]
// Toggle-handshake word crossing between two unrelated clock domains.
`timescale 1ns/10ps
module mdc_word_cross #(
  parameter int WIDTH = 8
) (
  input wire logic src_clock, // Clock of the sending side.
  input wire logic src_rst, // Asynchronous reset of the sending side.
  input wire logic src_valid, // One-cycle pulse: take src_data.
  input wire logic [WIDTH-1:0] src_data, // Word to send.
  input wire logic dst_clock, // Clock of the receiving side.
  input wire logic dst_rst, // Asynchronous reset of the receiving side.
  output logic dst_valid, // One-cycle pulse: dst_data is new.
  output logic [WIDTH-1:0] dst_data // Received word, held until the next.
);

  logic [WIDTH-1:0] hold;
  logic toggle;
  logic sync1;
  logic sync2;
  logic sync3;

  // ****************************************************************
  // Sending side
  // ****************************************************************
  // The word is held still from the toggle on, so the receiver may
  // sample it long after the toggle has settled.
  always_ff @(posedge src_clock or posedge src_rst) begin
    if (src_rst) begin
      hold <= '0;
      toggle <= 1'b0;
    end else if (src_valid) begin
      hold <= src_data;
      toggle <= ~toggle;
    end
  end

  // ****************************************************************
  // Receiving side
  // ****************************************************************
  // Only sync2 and sync3 feed the change detector.
  always_ff @(posedge dst_clock or posedge dst_rst) begin
    if (dst_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= toggle;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // The word is captured together with the pulse that announces it.
  always_ff @(posedge dst_clock or posedge dst_rst) begin
    if (dst_rst) begin
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      dst_valid <= sync2 ^ sync3;
      if (sync2 ^ sync3) begin
        dst_data <= hold;
      end
    end
  end

endmodule : mdc_word_cross

// [src/mdc_motion_config.sv]
// Motion-detection configuration registers with their serial port.
//
// Overview of operation
// - Threshold option 0: level limit is magnitude; 1: signed value.
// - Threshold option steers level detection only; pulse ignores it.
// - Filter bandwidth bit selects 62.5 Hz when clear, 125 Hz when set.
// - Level polarity 0: positive polarity, any enabled axis detects (OR).
// - Level polarity 1: negative polarity, all three axes needed (AND).
// - Pulse polarity 0: positive polarity, axes combined with OR.
// - Pulse polarity 1: negative polarity, axes combined with AND.
// - Drive bit selects standard (0) or strong (1) data-out drive.
// - Unsigned mode: 7-bit level threshold; host keeps its top bit 0.
// - Signed mode: whole level threshold byte is two's complement.
// - Pulse threshold is the unsigned low seven bits of its register.
// - Pulse duration counts 0.5 ms steps, 0.5 ms to 127.5 ms.
// - Latency time counts 1 ms steps, 1 ms to 255 ms.
// - Second window counts 1 ms steps; the minimum means single pulse.
// - Output is two's complement: 80, 00, 7F; one g per range.
// - Mode field: standby, measure, level detect, pulse detect.
`timescale 1ns/10ps
module mdc_motion_config #(
  parameter int HALF_MS_CYCLES = mdc_pkg::HALF_MS_CYCLES
) (
  input wire logic CLOCK, // Core clock, 250 MHz.
  input wire logic RST, // Asynchronous reset, active high.
  input wire logic SPI_CLK, // Serial port clock from the host.
  input wire logic SPI_CS_N, // Serial frame select, active low.
  input wire logic SPI_SDI, // Serial data from the host.
  output logic SPI_SDO, // Serial read data to the host.
  output logic SPI_SDO_OE, // High while SPI_SDO is driven.
  output logic MEASURE_ENABLE, // Any mode but standby.
  output logic LEVEL_DETECT_ENABLE, // Level detection mode.
  output logic PULSE_DETECT_ENABLE, // Pulse detection mode.
  output logic [7:0] LEVEL_LIMIT, // Level threshold as the detector uses it.
  output logic LEVEL_LIMIT_SIGNED, // Level limit is two's complement.
  output logic [6:0] PULSE_LIMIT, // Unsigned pulse threshold.
  output logic LEVEL_COMBINE_AND, // Level axes combine with AND.
  output logic PULSE_COMBINE_AND, // Pulse axes combine with AND.
  output logic FILTER_BW_SELECT, // Low-pass filter bandwidth select.
  output logic [16:0] FILTER_CUTOFF_MILLIHZ, // Chosen bandwidth in mHz.
  output logic OUTPUT_DRIVE_STRONG, // Strong drive on serial data out.
  output logic [1:0] RANGE_SELECT, // Measurement range code.
  output logic [7:0] ONE_G_CODE, // Output code of plus one g.
  output logic [7:0] PULSE_DURATION, // Pulse duration in 0.5 ms steps.
  output logic [7:0] LATENCY_TIME, // Latency in 1 ms steps.
  output logic [7:0] SECOND_WINDOW, // Second pulse window in 1 ms steps.
  output logic SINGLE_PULSE_ONLY, // Window at its minimum or off.
  output logic HALF_MS_TICK, // One-cycle pulse every 0.5 ms.
  output logic MS_TICK // One-cycle pulse every 1 ms.
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (HALF_MS_CYCLES < 2) begin : g_bad_tick
    $error("HALF_MS_CYCLES must be at least 2");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic link_rst;
  mdc_pkg::mdc_link_state_type link_state;
  logic [4:0] bit_count;
  logic [7:0] shift_in;
  logic [7:0] header;
  logic [7:0] next_shift_in;
  logic cmd_src_valid;
  logic [mdc_pkg::CMD_WIDTH-1:0] cmd_src_data;
  logic cmd_valid;
  logic [mdc_pkg::CMD_WIDTH-1:0] cmd_data;
  logic [7:0] read_word;
  logic [2:0] out_index;
  logic cmd_write;
  logic [5:0] cmd_addr;
  logic [7:0] cmd_value;
  logic rd_src_valid;
  logic [7:0] rd_src_data;
  logic [7:0] mode_control;
  logic [7:0] detection_control;
  logic [7:0] detection_polarity_control;
  logic [7:0] level_threshold;
  logic [7:0] pulse_threshold;
  logic [7:0] pulse_duration;
  logic [7:0] pulse_latency_time;
  logic [7:0] second_pulse_window;
  logic [1:0] mode;
  logic threshold_option;
  logic [31:0] tick_count;
  logic tick_phase;

  // ****************************************************************
  // Link side: serial frame on the host clock
  // ****************************************************************
  // Deselect ends the frame at once, since the host clock stops with it.
  assign link_rst = RST | SPI_CS_N;
  assign next_shift_in = {shift_in[6:0], SPI_SDI};

  // Frame sequencing: header, wait bits for the read fetch, data.
  always_ff @(posedge SPI_CLK or posedge link_rst) begin
    if (link_rst) begin
      link_state <= mdc_pkg::LINK_HEADER;
      bit_count <= 5'h00;
    end else begin
      if (bit_count != mdc_pkg::FRAME_BITS) begin
        bit_count <= bit_count + 5'h01;
      end
      case (link_state)
        mdc_pkg::LINK_HEADER: begin
          if (bit_count == mdc_pkg::HEADER_BITS - 5'h01) begin
            link_state <= mdc_pkg::LINK_WAIT;
          end
        end
        mdc_pkg::LINK_WAIT: begin
          if (bit_count == mdc_pkg::DATA_START - 5'h01) begin
            link_state <= mdc_pkg::LINK_DATA;
          end
        end
        mdc_pkg::LINK_DATA: begin
          if (bit_count == mdc_pkg::FRAME_BITS - 5'h01) begin
            link_state <= mdc_pkg::LINK_DONE;
          end
        end
        default: begin
          link_state <= mdc_pkg::LINK_DONE;
        end
      endcase
    end
  end

  // Incoming bits, most significant first; the header is kept whole.
  always_ff @(posedge SPI_CLK or posedge link_rst) begin
    if (link_rst) begin
      shift_in <= 8'h00;
      header <= 8'h00;
    end else begin
      shift_in <= next_shift_in;
      if (link_state == mdc_pkg::LINK_HEADER &&
          bit_count == mdc_pkg::HEADER_BITS - 5'h01) begin
        header <= next_shift_in;
      end
    end
  end

  // A read is asked for as soon as its header byte is complete, a write once
  // its data byte is complete.
  always_comb begin
    cmd_src_valid = 1'b0;
    cmd_src_data = '0;
    if (link_state == mdc_pkg::LINK_HEADER &&
        bit_count == mdc_pkg::HEADER_BITS - 5'h01 &&
        !next_shift_in[7]) begin
      cmd_src_valid = 1'b1;
      cmd_src_data = {1'b0, next_shift_in[6:1], 8'h00};
    end else if (link_state == mdc_pkg::LINK_DATA &&
                 bit_count == mdc_pkg::FRAME_BITS - 5'h01 &&
                 header[7]) begin
      cmd_src_valid = 1'b1;
      cmd_src_data = {1'b1, header[6:1], next_shift_in};
    end
  end

  // Read data leave on the falling edge so the host samples a settled bit.
  assign out_index = 3'h7 - 3'(bit_count - mdc_pkg::DATA_START);

  always_ff @(negedge SPI_CLK or posedge link_rst) begin
    if (link_rst) begin
      SPI_SDO <= 1'b0;
      SPI_SDO_OE <= 1'b0;
    end else if (link_state == mdc_pkg::LINK_DATA && !header[7]) begin
      SPI_SDO <= read_word[out_index];
      SPI_SDO_OE <= 1'b1;
    end else begin
      SPI_SDO <= 1'b0;
      SPI_SDO_OE <= 1'b0;
    end
  end

  // ****************************************************************
  // Crossings between the link and the core
  // ****************************************************************
  mdc_word_cross #(
    .WIDTH(mdc_pkg::CMD_WIDTH)
  ) u_cmd_cross (
    .src_clock(SPI_CLK),
    .src_rst(RST),
    .src_valid(cmd_src_valid),
    .src_data(cmd_src_data),
    .dst_clock(CLOCK),
    .dst_rst(RST),
    .dst_valid(cmd_valid),
    .dst_data(cmd_data)
  );

  // The wait bits give this word four link edges to arrive.
  mdc_word_cross #(
    .WIDTH(mdc_pkg::DATA_WIDTH)
  ) u_read_cross (
    .src_clock(CLOCK),
    .src_rst(RST),
    .src_valid(rd_src_valid),
    .src_data(rd_src_data),
    .dst_clock(SPI_CLK),
    .dst_rst(RST),
    .dst_valid(),
    .dst_data(read_word)
  );

  // ****************************************************************
  // Core side: register file
  // ****************************************************************
  assign cmd_write = cmd_data[mdc_pkg::CMD_WIDTH-1];
  assign cmd_addr = cmd_data[mdc_pkg::CMD_WIDTH-2:mdc_pkg::DATA_WIDTH];
  assign cmd_value = cmd_data[mdc_pkg::DATA_WIDTH-1:0];

  // Writes to unmapped addresses are dropped.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mode_control <= mdc_pkg::REG_RESET;
      detection_control <= mdc_pkg::REG_RESET;
      detection_polarity_control <= mdc_pkg::REG_RESET;
      level_threshold <= mdc_pkg::REG_RESET;
      pulse_threshold <= mdc_pkg::REG_RESET;
      pulse_duration <= mdc_pkg::REG_RESET;
      pulse_latency_time <= mdc_pkg::REG_RESET;
      second_pulse_window <= mdc_pkg::REG_RESET;
    end else if (cmd_valid && cmd_write) begin
      case (cmd_addr)
        mdc_pkg::MODE_CONTROL_OFFSET: mode_control <= cmd_value;
        mdc_pkg::DETECTION_CONTROL_OFFSET: detection_control <= cmd_value;
        mdc_pkg::DETECTION_POLARITY_CONTROL_OFFSET: begin
          detection_polarity_control <=
            cmd_value & mdc_pkg::POLARITY_USED_MASK;
        end
        mdc_pkg::LEVEL_THRESHOLD_OFFSET: level_threshold <= cmd_value;
        mdc_pkg::PULSE_THRESHOLD_OFFSET: pulse_threshold <= cmd_value;
        mdc_pkg::PULSE_DURATION_OFFSET: pulse_duration <= cmd_value;
        mdc_pkg::PULSE_LATENCY_TIME_OFFSET: pulse_latency_time <= cmd_value;
        mdc_pkg::SECOND_PULSE_WINDOW_OFFSET: begin
          second_pulse_window <= cmd_value;
        end
        default: begin
        end
      endcase
    end
  end

  // Read fetch; registers read back exactly as stored.
  always_comb begin
    rd_src_valid = cmd_valid && !cmd_write;
    case (cmd_addr)
      mdc_pkg::MODE_CONTROL_OFFSET: rd_src_data = mode_control;
      mdc_pkg::DETECTION_CONTROL_OFFSET: rd_src_data = detection_control;
      mdc_pkg::DETECTION_POLARITY_CONTROL_OFFSET: begin
        rd_src_data = detection_polarity_control;
      end
      mdc_pkg::LEVEL_THRESHOLD_OFFSET: rd_src_data = level_threshold;
      mdc_pkg::PULSE_THRESHOLD_OFFSET: rd_src_data = pulse_threshold;
      mdc_pkg::PULSE_DURATION_OFFSET: rd_src_data = pulse_duration;
      mdc_pkg::PULSE_LATENCY_TIME_OFFSET: rd_src_data = pulse_latency_time;
      mdc_pkg::SECOND_PULSE_WINDOW_OFFSET: rd_src_data = second_pulse_window;
      default: rd_src_data = mdc_pkg::UNMAPPED_READ;
    endcase
  end

  // ****************************************************************
  // Core side: settings presented to the detectors
  // ****************************************************************
  assign mode = mode_control[mdc_pkg::MODE_LSB +: 2];
  assign threshold_option = detection_control[mdc_pkg::THRESHOLD_OPTION_BIT];

  // Mode decode for the measurement path and both detectors.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      MEASURE_ENABLE <= 1'b0;
      LEVEL_DETECT_ENABLE <= 1'b0;
      PULSE_DETECT_ENABLE <= 1'b0;
    end else begin
      MEASURE_ENABLE <= mode != mdc_pkg::MODE_STANDBY;
      LEVEL_DETECT_ENABLE <= mode == mdc_pkg::MODE_LEVEL;
      PULSE_DETECT_ENABLE <= mode == mdc_pkg::MODE_PULSE;
    end
  end

  // Thresholds. In unsigned mode the top level bit is forced clear so a
  // host slip cannot turn a magnitude into a huge limit.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      LEVEL_LIMIT <= 8'h00;
      LEVEL_LIMIT_SIGNED <= 1'b0;
      PULSE_LIMIT <= 7'h00;
    end else begin
      LEVEL_LIMIT_SIGNED <= threshold_option;
      if (threshold_option) begin
        LEVEL_LIMIT <= level_threshold;
      end else begin
        LEVEL_LIMIT <= {1'b0, level_threshold[6:0]};
      end
      // The reserved top bit is left to the host and never used.
      PULSE_LIMIT <= pulse_threshold[6:0];
    end
  end

  // Axis combination, filter and pin drive selects.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      LEVEL_COMBINE_AND <= 1'b0;
      PULSE_COMBINE_AND <= 1'b0;
      FILTER_BW_SELECT <= 1'b0;
      FILTER_CUTOFF_MILLIHZ <= mdc_pkg::FILTER_LOW_MILLIHZ;
      OUTPUT_DRIVE_STRONG <= 1'b0;
    end else begin
      LEVEL_COMBINE_AND <=
        detection_polarity_control[mdc_pkg::LEVEL_POLARITY_BIT];
      // The line above
      PULSE_COMBINE_AND <=
        detection_polarity_control[mdc_pkg::PULSE_POLARITY_BIT];
      // The line above
      FILTER_BW_SELECT <=
        detection_control[mdc_pkg::FILTER_BANDWIDTH_BIT];
      FILTER_CUTOFF_MILLIHZ <=
        detection_control[mdc_pkg::FILTER_BANDWIDTH_BIT] ?
        mdc_pkg::FILTER_HIGH_MILLIHZ : mdc_pkg::FILTER_LOW_MILLIHZ;
      OUTPUT_DRIVE_STRONG <=
        detection_polarity_control[mdc_pkg::OUTPUT_DRIVE_BIT];
    end
  end

  // Range and the code that plus one g produces in it; minus one g is
  // its negation, and full scale is 80 and 7F in every range.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RANGE_SELECT <= mdc_pkg::RANGE_8G;
      ONE_G_CODE <= mdc_pkg::ONE_G_8G;
    end else begin
      RANGE_SELECT <= mode_control[mdc_pkg::RANGE_LSB +: 2];
      case (mode_control[mdc_pkg::RANGE_LSB +: 2])
        mdc_pkg::RANGE_2G: ONE_G_CODE <= mdc_pkg::ONE_G_2G;
        mdc_pkg::RANGE_4G: ONE_G_CODE <= mdc_pkg::ONE_G_4G;
        default: ONE_G_CODE <= mdc_pkg::ONE_G_8G;
      endcase
    end
  end

  // Pulse timing settings.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PULSE_DURATION <= 8'h00;
      LATENCY_TIME <= 8'h00;
      SECOND_WINDOW <= 8'h00;
      SINGLE_PULSE_ONLY <= 1'b1;
    end else begin
      PULSE_DURATION <= pulse_duration;
      LATENCY_TIME <= pulse_latency_time;
      SECOND_WINDOW <= second_pulse_window;
      SINGLE_PULSE_ONLY <=
        (second_pulse_window <= mdc_pkg::SINGLE_PULSE_WINDOW_MAX);
    end
  end

  // Time base for the pulse timers: a tick per duration step and one per
  // latency or window step, so the detectors count steps, not cycles.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tick_count <= 32'h00000000;
      tick_phase <= 1'b0;
      HALF_MS_TICK <= 1'b0;
      MS_TICK <= 1'b0;
    end else if (tick_count == 32'(HALF_MS_CYCLES - 1)) begin
      tick_count <= 32'h00000000;
      tick_phase <= ~tick_phase;
      HALF_MS_TICK <= 1'b1;
      MS_TICK <= tick_phase;
    end else begin
      tick_count <= tick_count + 32'h00000001;
      HALF_MS_TICK <= 1'b0;
      MS_TICK <= 1'b0;
    end
  end

endmodule : mdc_motion_config

// [tb/mdc_motion_config_asserts.sv]
// Concurrent checks on the configuration block's ports.
`timescale 1ns/10ps
module mdc_config_checker #(
  parameter int HALF_MS_CYCLES = 8
) (
  input wire logic CLOCK, // Core clock.
  input wire logic RST, // Reset, active high.
  input wire logic MEASURE_ENABLE, // Not standby.
  input wire logic LEVEL_DETECT_ENABLE, // Level mode.
  input wire logic PULSE_DETECT_ENABLE, // Pulse mode.
  input wire logic [7:0] LEVEL_LIMIT, // Level limit.
  input wire logic LEVEL_LIMIT_SIGNED, // Signed limit.
  input wire logic FILTER_BW_SELECT, // Bandwidth bit.
  input wire logic [16:0] FILTER_CUTOFF_MILLIHZ, // Bandwidth.
  input wire logic [1:0] RANGE_SELECT, // Range code.
  input wire logic [7:0] ONE_G_CODE, // Plus one g code.
  input wire logic [7:0] SECOND_WINDOW, // Window value.
  input wire logic SINGLE_PULSE_ONLY, // Single pulse.
  input wire logic HALF_MS_TICK, // Half ms pulse.
  input wire logic MS_TICK // One ms pulse.
);
  logic [31:0] gap;
  logic seen;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Cycles since the last half tick; the first tick after reset has no
  // reference point, so only later ones are judged.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      gap <= 32'h00000000;
      seen <= 1'b0;
    end else if (HALF_MS_TICK) begin
      gap <= 32'h00000000;
      seen <= 1'b1;
    end else begin
      gap <= gap + 32'h00000001;
    end
  end
  level_top_bit_a: assert property (
    !LEVEL_LIMIT_SIGNED |-> !LEVEL_LIMIT[7]) else $error("level top bit");
  cutoff_select_a: assert property (
    FILTER_CUTOFF_MILLIHZ == (FILTER_BW_SELECT ? 17'h1E848 : 17'h0F424))
    else $error("filter bandwidth");
  single_window_a: assert property (
    SINGLE_PULSE_ONLY == (SECOND_WINDOW <= 8'h01)) else $error("window");
  level_mode_a: assert property (
    LEVEL_DETECT_ENABLE |-> MEASURE_ENABLE && !PULSE_DETECT_ENABLE)
    else $error("level mode");
  pulse_mode_a: assert property (
    PULSE_DETECT_ENABLE |-> MEASURE_ENABLE && !LEVEL_DETECT_ENABLE)
    else $error("pulse mode");
  ms_half_a: assert property (
    MS_TICK |-> HALF_MS_TICK) else $error("ms tick alone");
  half_period_a: assert property (
    HALF_MS_TICK && seen |-> gap == 32'(HALF_MS_CYCLES - 1))
    else $error("half tick spacing");
  one_g_code_a: assert property (
    ONE_G_CODE == (RANGE_SELECT == 2'h1 ? 8'h3F :
    RANGE_SELECT == 2'h2 ? 8'h1F : 8'h0F)) else $error("one g code");
  cover property (LEVEL_DETECT_ENABLE);
  cover property (PULSE_DETECT_ENABLE);
  cover property (LEVEL_LIMIT_SIGNED && LEVEL_LIMIT[7]);
endmodule : mdc_config_checker
bind mdc_motion_config mdc_config_checker #(
  .HALF_MS_CYCLES(HALF_MS_CYCLES)) u_chk (.CLOCK, .RST, .MEASURE_ENABLE,
  .LEVEL_DETECT_ENABLE, .PULSE_DETECT_ENABLE, .LEVEL_LIMIT,
  .LEVEL_LIMIT_SIGNED, .FILTER_BW_SELECT, .FILTER_CUTOFF_MILLIHZ,
  .RANGE_SELECT, .ONE_G_CODE, .SECOND_WINDOW, .SINGLE_PULSE_ONLY,
  .HALF_MS_TICK, .MS_TICK);

// [tb/mdc_host_model.sv]
// Host model that drives frames on the serial register port.
`timescale 1ns/10ps
module mdc_host_model (
  output logic SPI_CLK, // Link clock, still outside frames.
  output logic SPI_CS_N, // Frame select, active low.
  output logic SPI_SDI, // Data to the device.
  input wire logic SPI_SDO, // Read data.
  input wire logic SPI_SDO_OE // High while read data are driven.
);
  // Idle levels before the first frame.
  initial begin
    SPI_CLK = 1'b0;
    SPI_CS_N = 1'b1;
    SPI_SDI = 1'b0;
  end
  // One frame of rw, address, pad, wait and data bits, MSB first.
  // An undriven read bit is taken inverted; the device holds SPI_SDO low then, so it reads as 1.
  task automatic xfer(input logic wr, input logic [5:0] a,
      input logic [7:0] d, output logic [7:0] q);
    logic [19:0] f;
    f = {wr, a, 1'b0, 4'h0, d};
    q = 8'h00;
    SPI_CS_N = 1'b0;
    #1.3;
    for (int i = 0; i < 20; i++) begin
      SPI_SDI = f[19-i];
      #24 SPI_CLK = 1'b1;
      if (i >= 12)
        q = {q[6:0], SPI_SDO_OE ? SPI_SDO : ~SPI_SDO};
      #24 SPI_CLK = 1'b0;
    end
    SPI_CS_N = 1'b1;
    SPI_SDI = ~SPI_SDI; // A released line shows no stale value.
    #24;
  endtask : xfer
endmodule : mdc_host_model

// [tb/tb_top.sv]
// Self-checking bench for the configuration register block.
`timescale 1ns/10ps
module tb_top;
  logic CLOCK, RST, SPI_CLK, SPI_CS_N, SPI_SDI, SPI_SDO, SPI_SDO_OE;
  logic MEASURE_ENABLE, LEVEL_DETECT_ENABLE, PULSE_DETECT_ENABLE;
  logic LEVEL_LIMIT_SIGNED, LEVEL_COMBINE_AND, PULSE_COMBINE_AND;
  logic FILTER_BW_SELECT, OUTPUT_DRIVE_STRONG, SINGLE_PULSE_ONLY;
  logic HALF_MS_TICK, MS_TICK;
  logic [7:0] LEVEL_LIMIT, ONE_G_CODE, PULSE_DURATION, LATENCY_TIME;
  logic [7:0] SECOND_WINDOW, q, nh, nm;
  logic [6:0] PULSE_LIMIT;
  logic [16:0] FILTER_CUTOFF_MILLIHZ;
  logic [1:0] RANGE_SELECT;
  logic [5:0] offs [8] = '{6'h16, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C,
    6'h1D, 6'h1E};
  logic [7:0] vals [2] = '{8'h01, 8'hFF};
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  mdc_motion_config #(.HALF_MS_CYCLES(8)) dut (.*);
  mdc_host_model host (.SPI_CLK, .SPI_CS_N, .SPI_SDI, .SPI_SDO,
    .SPI_SDO_OE);
  // Free-running core clock.
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Writes settle within a few core cycles; ten leave margin.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
    repeat (10) @(posedge CLOCK);
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk(32'(q), 32'(e));
  endtask : rd
  // A hung frame or wait ends the run here as a failure.
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    RST = 1'b1;
    repeat (4) @(posedge CLOCK);
    #1 RST = 1'b0;
    repeat (4) @(posedge CLOCK);
    #1;
    foreach (offs[i]) rd(offs[i], 8'h00);
    chk({FILTER_CUTOFF_MILLIHZ, ONE_G_CODE, SINGLE_PULSE_ONLY},
      {17'h0F424, 8'h0F, 1'b1});
    rd(6'h3F, 8'h00);
    $display("test 1 done");
    wr(6'h19, 8'hFF);
    rd(6'h19, 8'h07);
    chk({LEVEL_COMBINE_AND, PULSE_COMBINE_AND, OUTPUT_DRIVE_STRONG},
      3'h7);
    wr(6'h19, 8'h02);
    chk({LEVEL_COMBINE_AND, PULSE_COMBINE_AND, OUTPUT_DRIVE_STRONG},
      3'h2);
    wr(6'h19, 8'h05);
    chk({LEVEL_COMBINE_AND, PULSE_COMBINE_AND, OUTPUT_DRIVE_STRONG},
      3'h5);
    $display("test 2 done");
    // The host keeps the top level bit clear while the option is 0.
    wr(6'h1A, 8'h45);
    chk({LEVEL_LIMIT_SIGNED, LEVEL_LIMIT}, 9'h045);
    wr(6'h18, 8'hC0);
    wr(6'h1A, 8'h85);
    chk({LEVEL_LIMIT_SIGNED, LEVEL_LIMIT, FILTER_BW_SELECT,
      FILTER_CUTOFF_MILLIHZ}, {9'h185, 18'h3E848});
    wr(6'h1B, 8'h7F);
    chk(PULSE_LIMIT, 7'h7F);
    rd(6'h1A, 8'h85);
    $display("test 3 done");
    foreach (vals[j]) begin
      for (int i = 0; i < 3; i++)
        wr(6'h1C + 6'(i), vals[j]);
      chk({PULSE_DURATION, LATENCY_TIME, SECOND_WINDOW, SINGLE_PULSE_ONLY},
        {vals[j], vals[j], vals[j], vals[j] == 8'h01});
      for (int i = 0; i < 3; i++)
        rd(6'h1C + 6'(i), vals[j]);
    end
    nh = 8'h00;
    nm = 8'h00;
    repeat (64) begin
      @(posedge CLOCK);
      #1;
      nh = nh + 8'(HALF_MS_TICK);
      nm = nm + 8'(MS_TICK);
    end
    chk({nh, nm}, 16'h0804);
    $display("test 4 done");
    for (int m = 0; m < 16; m++) begin
      wr(6'h16, 8'(m));
      chk({MEASURE_ENABLE, LEVEL_DETECT_ENABLE, PULSE_DETECT_ENABLE,
        RANGE_SELECT, ONE_G_CODE}, {m[1:0] != 2'h0, m[1:0] == 2'h2,
        m[1:0] == 2'h3, m[3:2], m[3:2] == 2'h1 ? 8'h3F :
        m[3:2] == 2'h2 ? 8'h1F : 8'h0F});
    end
    $display("test 5 done");
    complete_run();
  end
endmodule : tb_top
